/* cpdt_pkg.sv */
/*
 * cpdt_pkg: constants and types of the second output port's high-speed
 * timing bank. It holds the register indices, field layout, reset values,
 * lane rate codes and sequencer states.
 * Assumes the user compiles it before every module that names it.
 */
package cpdt_pkg;

	// bank shape
	localparam int NUM_REGS = 7;
	localparam int REG_W = 8;
	localparam int VAL_W = 7;
	localparam int OV_BIT = 7;
	localparam int ADDR_W = 32;

	// register indices; the byte address is four times the index
	localparam logic [7:0] IDX_CLOCK_TRAIL = 8'h62;
	localparam logic [7:0] IDX_CLOCK_POST = 8'h63;
	localparam logic [7:0] IDX_DATA_PREPARE = 8'h64;
	localparam logic [7:0] IDX_DATA_ZERO = 8'h65;
	localparam logic [7:0] IDX_DATA_TRAIL = 8'h66;
	localparam logic [7:0] IDX_DATA_EXIT = 8'h67;
	localparam logic [7:0] IDX_LP_EXIT = 8'h68;
	localparam logic [7:0] IDX_LANE_RATE = 8'h69;
	localparam logic [7:0] IDX_LINK_STATUS = 8'h6a;

	// reset values, element 0 is the clock trail register
	localparam logic [NUM_REGS-1:0][REG_W-1:0] RST_TABLE = {
		8'h06, 8'h0b, 8'h08, 8'h0c, 8'h06, 8'h0a, 8'h0b
	};

	// lane rate codes
	typedef enum logic [2:0] {
		CPDT_RATE_400 = 3'h0,
		CPDT_RATE_800 = 3'h1,
		CPDT_RATE_1200 = 3'h2,
		CPDT_RATE_1500 = 3'h3,
		CPDT_RATE_1600 = 3'h4
	} cpdt_rate_t;

	localparam cpdt_rate_t RATE_RST = CPDT_RATE_800;

	// rate scale in eighths of the 800 Mbps figure
	localparam logic [4:0] SCALE_400 = 5'h04;
	localparam logic [4:0] SCALE_800 = 5'h08;
	localparam logic [4:0] SCALE_1200 = 5'h0c;
	localparam logic [4:0] SCALE_1500 = 5'h0f;
	localparam logic [4:0] SCALE_1600 = 5'h10;
	localparam int SCALE_SHIFT = 3;
	localparam logic [11:0] ROUND_UP = 12'h007;
	localparam logic [6:0] VAL_MAX = 7'h7f;

	// effective timing set, in high-speed byte clock cycles
	typedef struct packed {
		logic [6:0] clock_trail;
		logic [6:0] clock_post;
		logic [6:0] data_prepare;
		logic [6:0] data_zero;
		logic [6:0] data_trail;
		logic [6:0] data_exit;
		logic [6:0] lp_exit;
	} cpdt_timing_t;

	// lane sequencer states
	typedef enum logic [3:0] {
		CPDT_SEQ_IDLE = 4'h0,
		CPDT_SEQ_LPX = 4'h1,
		CPDT_SEQ_PREP = 4'h2,
		CPDT_SEQ_ZERO = 4'h3,
		CPDT_SEQ_SEND = 4'h4,
		CPDT_SEQ_DTRAIL = 4'h5,
		CPDT_SEQ_CPOST = 4'h6,
		CPDT_SEQ_CTRAIL = 4'h7,
		CPDT_SEQ_EXIT = 4'h8
	} cpdt_seq_t;

	// map a rate code to its scale; unknown codes never get stored
	function automatic logic [4:0] rate_scale(input cpdt_rate_t r);
		logic [4:0] s;
		s = SCALE_800;
		unique case (r)
			CPDT_RATE_400: s = SCALE_400;
			CPDT_RATE_800: s = SCALE_800;
			CPDT_RATE_1200: s = SCALE_1200;
			CPDT_RATE_1500: s = SCALE_1500;
			CPDT_RATE_1600: s = SCALE_1600;
			default: s = SCALE_800;
		endcase
		return s;
	endfunction : rate_scale

endpackage : cpdt_pkg

/* cpdt_lane_seq.sv */
/*
 * cpdt_lane_seq: high-speed entry and exit sequencer of the clock and
 * data lanes, timed by the effective timing set.
 * Assumes timing is stable, registered, and on clk_sys.
 */
`timescale 1ns/1ps
module cpdt_lane_seq (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// timing and request
	input wire cpdt_pkg::cpdt_timing_t timing,
	input wire logic hs_request,
	// lane controls
	output logic clk_lane_hs,
	output logic data_lane_hs,
	output logic hs_ready,
	output logic seq_busy,
	output cpdt_pkg::cpdt_seq_t seq_state
);

	cpdt_pkg::cpdt_seq_t state_q, state_d;
	logic [6:0] cnt_q, cnt_d;
	logic clk_hs_q, clk_hs_d, data_hs_q, data_hs_d;
	logic ready_q, ready_d, busy_q, busy_d;

	// a zero value still lasts one cycle
	function automatic logic [6:0] load(input logic [6:0] v);
		return (v == 7'h00) ? 7'h00 : v - 7'h01;
	endfunction : load

	// phase walk; each timed phase lasts its value in cycles
	always_comb begin
		state_d = state_q;
		cnt_d = (cnt_q != 7'h00) ? cnt_q - 7'h01 : 7'h00;
		unique case (state_q)
			cpdt_pkg::CPDT_SEQ_IDLE: if (hs_request) begin
				state_d = cpdt_pkg::CPDT_SEQ_LPX;
				cnt_d = load(timing.lp_exit);
			end
			cpdt_pkg::CPDT_SEQ_LPX: if (cnt_q == 7'h00) begin
				state_d = cpdt_pkg::CPDT_SEQ_PREP;
				cnt_d = load(timing.data_prepare);
			end
			cpdt_pkg::CPDT_SEQ_PREP: if (cnt_q == 7'h00) begin
				state_d = cpdt_pkg::CPDT_SEQ_ZERO;
				cnt_d = load(timing.data_zero);
			end
			cpdt_pkg::CPDT_SEQ_ZERO: if (cnt_q == 7'h00) begin
				state_d = cpdt_pkg::CPDT_SEQ_SEND;
			end
			cpdt_pkg::CPDT_SEQ_SEND: if (!hs_request) begin
				state_d = cpdt_pkg::CPDT_SEQ_DTRAIL;
				cnt_d = load(timing.data_trail);
			end
			cpdt_pkg::CPDT_SEQ_DTRAIL: if (cnt_q == 7'h00) begin
				state_d = cpdt_pkg::CPDT_SEQ_CPOST;
				cnt_d = load(timing.clock_post);
			end
			cpdt_pkg::CPDT_SEQ_CPOST: if (cnt_q == 7'h00) begin
				state_d = cpdt_pkg::CPDT_SEQ_CTRAIL;
				cnt_d = load(timing.clock_trail);
			end
			cpdt_pkg::CPDT_SEQ_CTRAIL: if (cnt_q == 7'h00) begin
				state_d = cpdt_pkg::CPDT_SEQ_EXIT;
				cnt_d = load(timing.data_exit);
			end
			cpdt_pkg::CPDT_SEQ_EXIT: if (cnt_q == 7'h00) begin
				state_d = cpdt_pkg::CPDT_SEQ_IDLE;
			end
			default: state_d = cpdt_pkg::CPDT_SEQ_IDLE;
		endcase
		clk_hs_d = (state_d >= cpdt_pkg::CPDT_SEQ_PREP) &&
			(state_d <= cpdt_pkg::CPDT_SEQ_CTRAIL);
		data_hs_d = (state_d >= cpdt_pkg::CPDT_SEQ_ZERO) &&
			(state_d <= cpdt_pkg::CPDT_SEQ_DTRAIL);
		ready_d = (state_d == cpdt_pkg::CPDT_SEQ_SEND);
		busy_d = (state_d != cpdt_pkg::CPDT_SEQ_IDLE);
	end

	// state registers
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			state_q <= cpdt_pkg::CPDT_SEQ_IDLE;
			cnt_q <= 7'h00;
			clk_hs_q <= 1'b0;
			data_hs_q <= 1'b0;
			ready_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			clk_hs_q <= clk_hs_d;
			data_hs_q <= data_hs_d;
			ready_q <= ready_d;
			busy_q <= busy_d;
		end
	end

	assign clk_lane_hs = clk_hs_q;
	assign data_lane_hs = data_hs_q;
	assign hs_ready = ready_q;
	assign seq_busy = busy_q;
	assign seq_state = state_q;

endmodule : cpdt_lane_seq

/* cpdt_timing_bank.sv */
/*
 * cpdt_timing_bank: AHB-Lite register bank of the second output port's
 * high-speed timing parameters, with automatic derivation from the lane
 * rate, per-parameter override, and the lane sequencer they drive.
 * Assumes a single AHB-Lite master doing whole-word single transfers and
 * that hs_request is synchronous to clk_sys.
 */
`timescale 1ns/1ps
module cpdt_timing_bank (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [cpdt_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// lane side
	input wire logic hs_request,
	output logic clk_lane_hs,
	output logic data_lane_hs,
	output logic hs_ready,
	output logic seq_busy,
	output cpdt_pkg::cpdt_timing_t timing
);

	localparam int N = cpdt_pkg::NUM_REGS;

	// bank state
	logic [N-1:0] ov_q, ov_d;
	logic [N-1:0][6:0] val_q, val_d;
	logic [N-1:0][6:0] auto_val;
	cpdt_pkg::cpdt_rate_t rate_q, rate_d;
	cpdt_pkg::cpdt_timing_t eff_q, eff_d;

	// bus state
	logic wr_pend_q, wr_pend_d;
	logic [7:0] wr_idx_q, wr_idx_d;
	logic [31:0] rdata_q, rdata_d;
	logic ready_q;

	// sequencer view
	logic seq_busy_w;
	cpdt_pkg::cpdt_seq_t seq_state_w;

	logic acc;
	logic [7:0] rd_idx;
	logic rd_mapped;
	logic wr_mapped;

	// derived value: 800 figure scaled by rate, rounded up, never zero
	function automatic logic [6:0] derive(input logic [6:0] base,
			input cpdt_pkg::cpdt_rate_t r);
		logic [11:0] p;
		logic [11:0] q;
		p = 12'({5'h00, base} * 12'(cpdt_pkg::rate_scale(r)));
		q = (p + cpdt_pkg::ROUND_UP) >> cpdt_pkg::SCALE_SHIFT;
		if (q > 12'(cpdt_pkg::VAL_MAX)) begin
			q = 12'(cpdt_pkg::VAL_MAX);
		end
		if (q == 12'h000) begin
			q = 12'h001;
		end
		return q[6:0];
	endfunction : derive

	// index of a bank register, or n when not a timing register
	function automatic logic [2:0] slot(input logic [7:0] idx);
		logic [7:0] off;
		off = idx - cpdt_pkg::IDX_CLOCK_TRAIL;
		return (idx >= cpdt_pkg::IDX_CLOCK_TRAIL &&
			idx <= cpdt_pkg::IDX_LP_EXIT) ? off[2:0] : 3'(N);
	endfunction : slot

	function automatic logic rate_legal(input logic [2:0] c);
		return c <= 3'(cpdt_pkg::CPDT_RATE_1600);
	endfunction : rate_legal

	// derived values follow the stored rate combinationally, in the same cycle
	always_comb begin
		for (int i = 0; i < N; i++) begin
			auto_val[i] = derive(cpdt_pkg::RST_TABLE[i][6:0],
				rate_q);
		end
	end

	// address phase decode; word aligned, upper bits must be zero
	assign acc = hsel && htrans[1] && hready;
	assign rd_idx = haddr[9:2];
	assign rd_mapped = (haddr[cpdt_pkg::ADDR_W-1:10] == '0);
	// only bank slots and the rate register take writes
	assign wr_mapped = (slot(wr_idx_q) != 3'(N)) ||
		(wr_idx_q == cpdt_pkg::IDX_LANE_RATE);

	// bank next state; a data phase write lands this cycle
	always_comb begin
		ov_d = ov_q;
		rate_d = rate_q;
		for (int i = 0; i < N; i++) begin
			// without override the field tracks the derived value
			val_d[i] = ov_q[i] ? val_q[i] : auto_val[i];
		end
		if (wr_pend_q && wr_mapped) begin
			for (int i = 0; i < N; i++) begin
				if (slot(wr_idx_q) == 3'(i)) begin
					ov_d[i] = hwdata[cpdt_pkg::OV_BIT];
					// value only lands with the override set
					val_d[i] = hwdata[cpdt_pkg::OV_BIT] ?
						hwdata[6:0] : auto_val[i];
				end
			end
			if (wr_idx_q == cpdt_pkg::IDX_LANE_RATE &&
					rate_legal(hwdata[2:0])) begin
				rate_d = cpdt_pkg::cpdt_rate_t'(hwdata[2:0]);
			end
		end
	end

	// effective set: stored field is override or derived value
	always_comb begin
		eff_d.clock_trail = val_q[0];
		eff_d.clock_post = val_q[1];
		eff_d.data_prepare = val_q[2];
		eff_d.data_zero = val_q[3];
		eff_d.data_trail = val_q[4];
		eff_d.data_exit = val_q[5];
		eff_d.lp_exit = val_q[6];
	end

	// bus next state; read data built from next values so a read right
	// after a write to the same register sees the new contents
	always_comb begin
		wr_pend_d = acc && hwrite && rd_mapped;
		wr_idx_d = acc ? rd_idx : wr_idx_q;
		rdata_d = rdata_q;
		if (acc && !hwrite) begin
			rdata_d = 32'h0000_0000;
			if (rd_mapped) begin
				for (int i = 0; i < N; i++) begin
					if (slot(rd_idx) == 3'(i)) begin
						rdata_d[7:0] = {ov_d[i], val_d[i]};
					end
				end
				if (rd_idx == cpdt_pkg::IDX_LANE_RATE) begin
					rdata_d[2:0] = rate_d;
				end
				if (rd_idx == cpdt_pkg::IDX_LINK_STATUS) begin
					rdata_d[4:0] = {seq_state_w, seq_busy_w};
				end
			end
		end
	end

	// bank registers; override bits clear so all start derived
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			ov_q <= '0;
			for (int i = 0; i < N; i++) begin
				val_q[i] <= cpdt_pkg::RST_TABLE[i][6:0];
			end
			rate_q <= cpdt_pkg::RATE_RST;
			eff_q <= cpdt_pkg::cpdt_timing_t'({
				cpdt_pkg::RST_TABLE[0][6:0], cpdt_pkg::RST_TABLE[1][6:0],
				cpdt_pkg::RST_TABLE[2][6:0], cpdt_pkg::RST_TABLE[3][6:0],
				cpdt_pkg::RST_TABLE[4][6:0], cpdt_pkg::RST_TABLE[5][6:0],
				cpdt_pkg::RST_TABLE[6][6:0]});
		end else begin
			ov_q <= ov_d;
			val_q <= val_d;
			rate_q <= rate_d;
			eff_q <= eff_d;
		end
	end

	// bus registers; the slave never stalls and always answers okay
	always_ff @(posedge clk_sys) begin
		if (!resetn) begin
			wr_pend_q <= 1'b0;
			wr_idx_q <= 8'h00;
			rdata_q <= 32'h0000_0000;
			ready_q <= 1'b1;
		end else begin
			wr_pend_q <= wr_pend_d;
			wr_idx_q <= wr_idx_d;
			rdata_q <= rdata_d;
			ready_q <= 1'b1;
		end
	end

	// lane sequencer timed by the effective set
	cpdt_lane_seq u_seq (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.timing(eff_q),
		.hs_request(hs_request),
		.clk_lane_hs(clk_lane_hs),
		.data_lane_hs(data_lane_hs),
		.hs_ready(hs_ready),
		.seq_busy(seq_busy_w),
		.seq_state(seq_state_w)
	);

	assign seq_busy = seq_busy_w;
	assign hreadyout = ready_q;
	assign hresp = 1'b0;
	assign hrdata = rdata_q;
	assign timing = eff_q;

endmodule : cpdt_timing_bank

/* cpdt_timing_bank_sva.sv */
/*
 * cpdt_timing_bank_sva: port checker of the timing bank.
 * Assumes it is bound to cpdt_timing_bank, one clock, sync reset.
 */
`timescale 1ns/1ps
module cpdt_timing_bank_sva (
	// clock and reset
	input wire logic clk_sys,
	input wire logic resetn,
	// bus side
	input wire logic hsel,
	input wire logic [cpdt_pkg::ADDR_W-1:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic hresp,
	input wire logic [31:0] hrdata,
	// lane side
	input wire logic hs_request,
	input wire logic clk_lane_hs,
	input wire logic data_lane_hs,
	input wire logic hs_ready,
	input wire logic seq_busy,
	input wire cpdt_pkg::cpdt_timing_t timing
);
	localparam cpdt_pkg::cpdt_timing_t RV =
		{7'h0b, 7'h0a, 7'h06, 7'h0c, 7'h08, 7'h0b, 7'h06};

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!resetn);

	// address phase of a write to the clock trail, then its data phase
	sequence s_trail_wr;
		hsel && htrans[1] && hready && hwrite && haddr == 32'h188
		##1 hwdata[7];
	endsequence
	// any accepted read whose word index lies outside the bank
	sequence s_unmapped_rd;
		hsel && htrans[1] && hready && !hwrite &&
		!(haddr[9:2] inside {[8'h62:8'h6a]});
	endsequence

	a_trail_ovr: assert property (s_trail_wr |-> ##2
		timing.clock_trail == $past(hwdata[6:0], 2))
		else $error("trail override not applied");
	a_reset_vals: assert property ($rose(resetn) |-> timing == RV)
		else $error("timing not at reset values");
	a_unmapped_rd: assert property (s_unmapped_rd |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	a_resp_okay: assert property (hresp == 1'b0)
		else $error("bus response not okay");
	a_busy_start: assert property (!seq_busy && hs_request |->
		##[1:2] seq_busy)
		else $error("request not taken");
	a_ready_lanes: assert property (hs_ready |-> clk_lane_hs && data_lane_hs)
		else $error("ready without both lanes");
	a_data_in_clk: assert property (data_lane_hs |-> clk_lane_hs)
		else $error("data lane outside clock lane");
	a_clk_busy: assert property (clk_lane_hs |-> seq_busy)
		else $error("clock lane while idle");
	a_ready_drop: assert property (hs_ready && !hs_request |->
		##[1:2] !hs_ready)
		else $error("ready held after request drop");
endmodule : cpdt_timing_bank_sva

bind cpdt_timing_bank cpdt_timing_bank_sva u_sva (.clk_sys, .resetn,
	.hsel, .haddr, .htrans, .hwrite, .hwdata, .hready, .hresp, .hrdata,
	.hs_request, .clk_lane_hs, .data_lane_hs, .hs_ready, .seq_busy,
	.timing);

/* cpdt_timing_bank_tb.sv */
/*
 * cpdt_timing_bank_tb: random and corner tests of the timing bank.
 * Assumes the package, the design and its checker compile first.
 */
`timescale 1ns/1ps
module cpdt_timing_bank_tb;
	logic clk_sys, resetn, hsel, hwrite, hs_request, hreadyout, hresp;
	logic clk_lane_hs, data_lane_hs, hs_ready, seq_busy;
	logic [31:0] haddr, hwdata, hrdata, rd, lf;
	logic [1:0] htrans;
	logic [2:0] hsize;
	cpdt_pkg::cpdt_timing_t timing;
	int miscompares, compares, cyc;
	logic [7:0] rv [7] = '{8'h0b, 8'h0a, 8'h06, 8'h0c, 8'h08, 8'h0b, 8'h06};
	logic [6:0] ex [7];

	// hready follows the only slave
	cpdt_timing_bank uut (.clk_sys(clk_sys), .resetn(resetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
		.hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
		.hresp(hresp), .hrdata(hrdata), .hs_request(hs_request),
		.clk_lane_hs(clk_lane_hs), .data_lane_hs(data_lane_hs),
		.hs_ready(hs_ready), .seq_busy(seq_busy), .timing(timing));

	// 200 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end

	// hang guard, far above the few hundred cycles needed
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			miscompares++;
			end_of_test();
		end
	end

	function automatic logic [31:0] nx(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction : nx

	// derived value: reset value scaled by rate, rounded up, clamped
	function automatic logic [6:0] der(input int k, input int r);
		int s;
		int v;
		s = r == 0 ? 4 : r == 1 ? 8 : r == 2 ? 12 : r == 3 ? 15 : 16;
		v = (rv[k] * s + 7) / 8;
		return v > 127 ? 7'h7f : v[6:0];
	endfunction : der

	task automatic chk(input string n, input logic [63:0] e,
		input logic [63:0] g);
		compares++;
		if (g !== e) begin
			miscompares++;
			$display("CHECK FAILED %s exp %h got %h", n, e, g);
		end
	endtask : chk

	// one single transfer; hold each phase until hready is seen
	task automatic bus(input logic w, input logic [7:0] i,
		input logic [31:0] d);
		hsel <= 1'b1;
		htrans <= 2'b10;
		hwrite <= w;
		haddr <= {22'h0, i, 2'b00};
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= d;
		do @(posedge clk_sys); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : bus

	task automatic rchk(input string n, input logic [7:0] i,
		input logic [31:0] e);
		bus(1'b0, i, 32'h0);
		chk(n, e, rd);
	endtask : rchk

	task automatic tchk;
		chk("timing", {ex[0], ex[1], ex[2], ex[3], ex[4], ex[5], ex[6]},
			timing);
	endtask : tchk

	// edges until s reads v
	task automatic till(ref logic s, input logic v, output int n);
		n = 0;
		do begin
			@(posedge clk_sys);
			n++;
		end while (s !== v);
	endtask : till

	// one burst; phase lengths seen as gaps between lane edges
	task automatic lane;
		int n;
		hs_request <= 1'b1;
		till(seq_busy, 1'b1, n);
		till(clk_lane_hs, 1'b1, n);
		chk("lp_exit", ex[6], n);
		till(data_lane_hs, 1'b1, n);
		chk("prepare", ex[2], n);
		till(hs_ready, 1'b1, n);
		chk("zero", ex[3], n);
		// still sending: status shows the send state and busy
		rchk("status", 8'h6a, 32'h9);
		hs_request <= 1'b0;
		till(data_lane_hs, 1'b0, n);
		chk("trail", ex[4] + 2, n);
		till(clk_lane_hs, 1'b0, n);
		chk("post_trail", ex[1] + ex[0], n);
		till(seq_busy, 1'b0, n);
		chk("exit", ex[5], n);
	endtask : lane

	task automatic end_of_test;
		$display("compares %0d miscompares %0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test

	// main sequence
	initial begin
		static int codes [6] = '{1, 0, 2, 3, 4, 7};
		int cur;
		resetn = 1'b0;
		hsel = 1'b0;
		haddr = 32'h0;
		htrans = 2'b00;
		hwrite = 1'b0;
		hsize = 3'h2;
		hwdata = 32'h0;
		hs_request = 1'b0;
		lf = 32'hdb86;
		cur = 1;
		repeat (4) @(posedge clk_sys);
		resetn <= 1'b1;
		// every rate, then an illegal code; writes with the override clear ignored
		for (int i = 0; i < 6; i++) begin
			if (i > 0) bus(1'b1, 8'h69, codes[i]);
			if (codes[i] < 5) cur = codes[i];
			repeat (2) @(posedge clk_sys);
			for (int k = 0; k < 7; k++) begin
				ex[k] = der(k, cur);
				rchk("derived", 8'(8'h62 + k), {25'h0, ex[k]});
				lf = nx(lf);
				bus(1'b1, 8'(8'h62 + k), {25'h0, lf[6:0]});
			end
			rchk("rate", 8'h69, cur);
			tchk();
			if (i == 1) lane();
		end
		// unmapped place
		bus(1'b1, 8'h70, lf);
		rchk("unmapped", 8'h70, 32'h0);
		// overrides, wide then short values for a burst
		for (int p = 0; p < 2; p++) begin
			for (int k = 0; k < 7; k++) begin
				lf = nx(lf);
				ex[k] = p > 0 ? 7'(lf[2:0]) + 7'h1 : lf[6:0];
				if (p == 0 && k == 0) ex[k] = 7'h7f;
				bus(1'b1, 8'(8'h62 + k), {24'h0, 1'b1, ex[k]});
				rchk("override", 8'(8'h62 + k), {24'h0, 1'b1, ex[k]});
			end
			tchk();
		end
		lane();
		// clearing the override returns the derived value
		for (int k = 0; k < 7; k++) begin
			bus(1'b1, 8'(8'h62 + k), 32'h0);
			ex[k] = der(k, cur);
			rchk("released", 8'(8'h62 + k), {25'h0, ex[k]});
		end
		// reset in mid-run clears overrides and returns the rate to the 800 code
		bus(1'b1, 8'h62, 32'h85);
		resetn <= 1'b0;
		repeat (4) @(posedge clk_sys);
		resetn <= 1'b1;
		for (int k = 0; k < 7; k++) begin
			ex[k] = rv[k][6:0];
			rchk("reset", 8'(8'h62 + k), {24'h0, rv[k]});
		end
		rchk("rate_reset", 8'h69, 32'h1);
		rchk("status_reset", 8'h6a, 32'h0);
		tchk();
		end_of_test();
	end
endmodule : cpdt_timing_bank_tb
